// File: design/bsc_pkg.sv
package bsc_pkg;

  localparam int unsigned BSC_DATA_W = 32;
  localparam int unsigned BSC_ADDR_W = 16;
  localparam int unsigned BSC_SEL_W  = 4;
  localparam int unsigned BSC_IRQ_W  = 3;
  localparam int unsigned BSC_FB_W   = 13;

  // Register byte addresses.
  localparam logic [BSC_ADDR_W-1:0] BSC_OFF_PARAM       = 16'h8200;
  localparam logic [BSC_ADDR_W-1:0] BSC_OFF_LAUNCH      = 16'h8204;
  localparam logic [BSC_ADDR_W-1:0] BSC_OFF_STATUS_MODE = 16'h820c;
  localparam logic [BSC_ADDR_W-1:0] BSC_OFF_IRQ_STATUS  = 16'h8220;
  localparam logic [BSC_ADDR_W-1:0] BSC_OFF_IRQ_MASK    = 16'h8224;

  // Field positions in the status and mode word, and the write byte lanes for mode and interrupt registers.
  localparam int unsigned BSC_BIT_XFER      = 0;
  localparam int unsigned BSC_BIT_PIPE      = 1;
  localparam int unsigned BSC_BIT_PENDING   = 2;
  localparam int unsigned BSC_BIT_DEPTH     = 8;
  localparam int unsigned BSC_WIDTH_LSB     = 9;
  localparam int unsigned BSC_WIDTH_MSB     = 10;
  localparam int unsigned BSC_MODE_LANE     = 1;
  localparam int unsigned BSC_IRQ_LANE      = 0;

  // Interrupt event positions.
  localparam int unsigned BSC_IRQ_DONE = 0;
  localparam int unsigned BSC_IRQ_PIPE = 1;
  localparam int unsigned BSC_IRQ_LOST = 2;

  // Screen-width codes and decoded frame-buffer widths in bytes.
  localparam logic [1:0]          BSC_WSEL_1K = 2'h0;
  localparam logic [1:0]          BSC_WSEL_2K = 2'h1;
  localparam logic [BSC_FB_W-1:0] BSC_FB_1K   = 13'h0400;
  localparam logic [BSC_FB_W-1:0] BSC_FB_2K   = 13'h0800;
  localparam logic [BSC_FB_W-1:0] BSC_FB_4K   = 13'h1000;

  localparam logic [BSC_DATA_W-1:0] BSC_STATUS_MODE_RESET = 32'h00000000;

  typedef enum logic [1:0] {
    BSC_ENG_IDLE  = 2'b00,
    BSC_ENG_RUN   = 2'b01,
    BSC_ENG_DRAIN = 2'b10
  } bsc_eng_e;

  typedef struct packed {
    logic                  valid;
    logic                  we;
    logic [BSC_ADDR_W-1:0] addr;
    logic [BSC_DATA_W-1:0] wdata;
    logic [BSC_SEL_W-1:0]  sel;
  } bsc_req_s;

  typedef struct packed {
    logic [1:0] width_sel;
    logic       depth16;
  } bsc_mode_s;

  typedef struct packed {
    bsc_mode_s             mode;
    logic [BSC_FB_W-1:0]   fb_width;
    logic [BSC_DATA_W-1:0] param;
    logic [BSC_DATA_W-1:0] command;
    logic                  pending;
    bsc_eng_e              eng;
    logic                  mem_seen;
    logic                  start;
    logic [BSC_DATA_W-1:0] op_param;
    logic [BSC_DATA_W-1:0] op_command;
  } bsc_core_s;

  typedef struct packed {
    logic                  ack;
    logic [BSC_DATA_W-1:0] dat;
  } bsc_wb_s;

  typedef struct packed {
    logic [BSC_IRQ_W-1:0] status;
    logic [BSC_IRQ_W-1:0] mask;
    logic                 irq;
  } bsc_irq_s;

endpackage

// File: design/bsc_wb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module bsc_wb_slave
  import bsc_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [BSC_ADDR_W-1:0] wb_adr_i,
  input  wire logic [BSC_DATA_W-1:0] wb_dat_i,
  input  wire logic [BSC_SEL_W-1:0]  wb_sel_i,
  output logic                       wb_ack_o,
  output logic [BSC_DATA_W-1:0]      wb_dat_o,
  output bsc_req_s                   req,
  input  wire logic [BSC_DATA_W-1:0] rdata
);

  bsc_wb_s st_reg;
  bsc_wb_s st_next;

  // An access is taken once per request; ack blocks a second take.
  assign req.valid = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign req.we    = wb_we_i;
  assign req.addr  = wb_adr_i;
  assign req.wdata = wb_dat_i;
  assign req.sel   = wb_sel_i;

  always_comb begin
    st_next     = st_reg;
    st_next.ack = req.valid;
    if (req.valid && !wb_we_i) begin
      st_next.dat = rdata;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.dat;

  chk_ack_one_cycle: assert property (@(posedge core_clk) disable iff (reset)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  chk_ack_follows_req: assert property (@(posedge core_clk) disable iff (reset)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in the next cycle");

endmodule
`default_nettype wire

// File: design/bsc_irq.sv
`timescale 1ns/1ps
`default_nettype none
module bsc_irq
  import bsc_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic [BSC_IRQ_W-1:0] events,
  input  wire logic                 clr_we,
  input  wire logic                 mask_we,
  input  wire logic [BSC_IRQ_W-1:0] wr_bits,
  output logic      [BSC_IRQ_W-1:0] status,
  output logic      [BSC_IRQ_W-1:0] mask,
  output logic                      irq
);

  bsc_irq_s             st_reg;
  bsc_irq_s             st_next;
  logic [BSC_IRQ_W-1:0] status_upd;

  // A new event wins over a one-written clear in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < BSC_IRQ_W; gi++) begin : g_bit
      assign status_upd[gi] = events[gi] | (st_reg.status[gi] & ~(clr_we & wr_bits[gi]));
    end
  endgenerate

  always_comb begin
    st_next        = st_reg;
    st_next.status = status_upd;
    if (mask_we) begin
      st_next.mask = wr_bits;
    end
    st_next.irq = |(st_next.status & st_next.mask);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status = st_reg.status;
  assign mask   = st_reg.mask;
  assign irq    = st_reg.irq;

  chk_set_beats_clear: assert property (@(posedge core_clk) disable iff (reset)
    (events != '0) |=> ((status & $past(events)) == $past(events)))
    else $error("interrupt event lost");

endmodule
`default_nettype wire

// File: design/bsc_blit_status_mode.sv
// Functional notes
// RULE1 - Width code 00/01/1x gives 1K/2K/4K bytes.
// RULE2 - Software sets width to real frame-buffer width.
// RULE3 - Bit 8 selects 16-bit pixels, else 8-bit.
// RULE4 - Bit 2 high while loaded operation waits.
// RULE5 - Software waits for pending clear before parameter writes.
// RULE6 - Parameter write while pending overwrites queued operation.
// RULE7 - Bit 1 high while pipeline datapath processes.
// RULE8 - Software waits pipeline idle before reloading buffer.
// RULE9 - Bit 0 high while an operation runs.
// RULE10 - Transfer flag holds until memory requests complete.
// RULE11 - Software waits transfer idle before frame-buffer access.
// RULE12 - Status and mode word resets to zero.
// RULE13 - Writes change only width and depth fields.
`timescale 1ns/1ps
`default_nettype none
module bsc_blit_status_mode
  import bsc_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [BSC_ADDR_W-1:0] wb_adr_i,
  input  wire logic [BSC_DATA_W-1:0] wb_dat_i,
  input  wire logic [BSC_SEL_W-1:0]  wb_sel_i,
  output logic                       wb_ack_o,
  output logic [BSC_DATA_W-1:0]      wb_dat_o,
  input  wire logic                  pipe_done,
  input  wire logic                  mem_done,
  output logic                       op_start,
  output logic [BSC_DATA_W-1:0]      op_param,
  output logic [BSC_DATA_W-1:0]      op_command,
  output logic [BSC_FB_W-1:0]        fb_width_bytes,
  output logic                       pixel_16bpp,
  output logic                       transfer_pending,
  output logic                       pipeline_active,
  output logic                       transfer_active,
  output logic                       irq
);

  bsc_core_s             st_reg;
  bsc_core_s             st_next;
  bsc_req_s              req;
  logic [BSC_DATA_W-1:0] rdata;
  logic [BSC_DATA_W-1:0] status_word;
  logic [BSC_DATA_W-1:0] wmask;
  logic [BSC_IRQ_W-1:0]  irq_status;
  logic [BSC_IRQ_W-1:0]  irq_mask;
  logic [BSC_IRQ_W-1:0]  events;
  logic                  wr;
  logic                  wr_param;
  logic                  wr_launch;
  logic                  wr_mode;
  logic                  wr_irq_clr;
  logic                  wr_irq_mask;
  logic                  start;
  logic                  lost;
  logic                  finish;

  function automatic logic [BSC_FB_W-1:0] fb_bytes(input logic [1:0] code);
    logic [BSC_FB_W-1:0] val;
    unique case (code)
      BSC_WSEL_1K: val = BSC_FB_1K;
      BSC_WSEL_2K: val = BSC_FB_2K;
      default:     val = BSC_FB_4K;
    endcase
    return val;
  endfunction

  bsc_wb_slave u_wb (
    .core_clk (core_clk),
    .reset    (reset),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_ack_o (wb_ack_o),
    .wb_dat_o (wb_dat_o),
    .req      (req),
    .rdata    (rdata)
  );

  bsc_irq u_irq (
    .core_clk (core_clk),
    .reset    (reset),
    .events   (events),
    .clr_we   (wr_irq_clr),
    .mask_we  (wr_irq_mask),
    .wr_bits  (req.wdata[BSC_IRQ_W-1:0]),
    .status   (irq_status),
    .mask     (irq_mask),
    .irq      (irq)
  );

  // Byte-lane mask for partial writes of the word registers.
  genvar gi;
  generate
    for (gi = 0; gi < BSC_SEL_W; gi++) begin : g_lane
      assign wmask[8*gi +: 8] = {8{req.sel[gi]}};
    end
  endgenerate

  assign wr          = req.valid & req.we;
  assign wr_param    = wr & (req.addr[15:2] == BSC_OFF_PARAM[15:2]);
  assign wr_launch   = wr & (req.addr[15:2] == BSC_OFF_LAUNCH[15:2]);
  assign wr_mode     = wr & (req.addr[15:2] == BSC_OFF_STATUS_MODE[15:2]) & req.sel[BSC_MODE_LANE];
  assign wr_irq_clr  = wr & (req.addr[15:2] == BSC_OFF_IRQ_STATUS[15:2]) & req.sel[BSC_IRQ_LANE];
  assign wr_irq_mask = wr & (req.addr[15:2] == BSC_OFF_IRQ_MASK[15:2]) & req.sel[BSC_IRQ_LANE];

  // Status flags are built from engine state, so written values never reach them.
  always_comb begin
    status_word                              = BSC_STATUS_MODE_RESET; // see RULE13
    status_word[BSC_WIDTH_MSB:BSC_WIDTH_LSB] = st_reg.mode.width_sel;
    status_word[BSC_BIT_DEPTH]               = st_reg.mode.depth16;
    status_word[BSC_BIT_PENDING]             = st_reg.pending; // see RULE4
    status_word[BSC_BIT_PIPE]                = (st_reg.eng == BSC_ENG_RUN); // see RULE7
    status_word[BSC_BIT_XFER]                = (st_reg.eng != BSC_ENG_IDLE); // see RULE9
  end

  // Unmapped addresses read as zero and are still acknowledged.
  always_comb begin
    rdata = '0;
    case (req.addr[15:2])
      BSC_OFF_PARAM[15:2]:       rdata = st_reg.param;
      BSC_OFF_LAUNCH[15:2]:      rdata = st_reg.command;
      BSC_OFF_STATUS_MODE[15:2]: rdata = status_word;
      BSC_OFF_IRQ_STATUS[15:2]:  rdata[BSC_IRQ_W-1:0] = irq_status;
      BSC_OFF_IRQ_MASK[15:2]:    rdata[BSC_IRQ_W-1:0] = irq_mask;
      default:                   rdata = '0;
    endcase
  end

  always_comb begin
    st_next       = st_reg;
    st_next.start = 1'b0;
    start         = (st_reg.eng == BSC_ENG_IDLE) && st_reg.pending;
    finish        = 1'b0;
    if (wr_mode) begin
      st_next.mode.width_sel = req.wdata[BSC_WIDTH_MSB:BSC_WIDTH_LSB]; // see RULE13
      st_next.mode.depth16   = req.wdata[BSC_BIT_DEPTH]; // see RULE3
    end
    st_next.fb_width = fb_bytes(st_next.mode.width_sel); // see RULE1
    // A write over a queued operation replaces its values in place.
    if (wr_param) begin
      st_next.param = (st_reg.param & ~wmask) | (req.wdata & wmask); // see RULE6
    end
    if (wr_launch) begin
      st_next.command = (st_reg.command & ~wmask) | (req.wdata & wmask); // see RULE6
    end
    if (start) begin
      st_next.op_param   = st_reg.param;
      st_next.op_command = st_reg.command;
      st_next.start      = 1'b1;
    end
    st_next.pending = (st_reg.pending & ~start) | wr_launch; // see RULE4
    lost            = (wr_param | wr_launch) & st_reg.pending & ~start; // see RULE6
    unique case (st_reg.eng)
      BSC_ENG_IDLE: begin
        if (start) begin
          st_next.eng      = BSC_ENG_RUN; // see RULE7
          st_next.mem_seen = 1'b0;
        end
      end
      BSC_ENG_RUN: begin
        if (mem_done) begin
          st_next.mem_seen = 1'b1;
        end
        if (pipe_done) begin
          // The transfer stays busy until memory has finished too.
          if (st_reg.mem_seen || mem_done) begin
            st_next.eng = BSC_ENG_IDLE;
            finish      = 1'b1;
          end else begin
            st_next.eng = BSC_ENG_DRAIN; // see RULE10
          end
        end
      end
      BSC_ENG_DRAIN: begin
        if (mem_done) begin
          st_next.eng = BSC_ENG_IDLE; // see RULE10
          finish      = 1'b1;
        end
      end
      default: begin
        st_next.eng = BSC_ENG_IDLE;
      end
    endcase
    events               = '0;
    events[BSC_IRQ_DONE] = finish;
    events[BSC_IRQ_PIPE] = (st_reg.eng == BSC_ENG_RUN) && pipe_done;
    events[BSC_IRQ_LOST] = lost;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg          <= '0; // see RULE12
      st_reg.fb_width <= BSC_FB_1K; // see RULE12
    end else begin
      st_reg <= st_next;
    end
  end

  assign op_start         = st_reg.start;
  assign op_param         = st_reg.op_param;
  assign op_command       = st_reg.op_command;
  assign fb_width_bytes   = st_reg.fb_width;
  assign pixel_16bpp      = st_reg.mode.depth16;
  assign transfer_pending = status_word[BSC_BIT_PENDING];
  assign pipeline_active  = status_word[BSC_BIT_PIPE];
  assign transfer_active  = status_word[BSC_BIT_XFER];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_width_decode: assert property ( // see RULE1
    fb_width_bytes == fb_bytes(st_reg.mode.width_sel))
    else $error("frame-buffer width does not match width code");

  chk_width_write: assert property ( // see RULE1
    (wr_mode && req.wdata[BSC_WIDTH_MSB]) |=> (fb_width_bytes == BSC_FB_4K))
    else $error("upper width codes do not give 4096 bytes");

  chk_depth_write: assert property ( // see RULE3
    wr_mode |=> (pixel_16bpp == $past(req.wdata[BSC_BIT_DEPTH])))
    else $error("pixel depth did not follow write");

  chk_pending_set: assert property ( // see RULE4
    wr_launch |=> transfer_pending)
    else $error("launch did not raise pending flag");

  chk_pending_issue: assert property ( // see RULE4
    (transfer_pending && !transfer_active) |=> (op_start && pipeline_active))
    else $error("pending operation not issued to idle pipeline");

  chk_param_replace: assert property ( // see RULE6
    (wr_param && transfer_pending && !start && (req.sel == 4'hf))
    |=> (transfer_pending && (st_reg.param == $past(req.wdata))))
    else $error("queued parameters not overwritten");

  chk_pipe_flag: assert property ( // see RULE7
    op_start |-> (pipeline_active && transfer_active && $past(transfer_pending)))
    else $error("pipeline flag not set at operation start");

  chk_pipe_drop: assert property ( // see RULE7
    (pipeline_active && pipe_done) |=> !pipeline_active)
    else $error("pipeline flag did not drop on datapath completion");

  chk_xfer_cover: assert property ( // see RULE9
    pipeline_active |-> transfer_active)
    else $error("transfer flag low while pipeline runs");

  chk_xfer_hold: assert property ( // see RULE10
    (transfer_active && !pipeline_active && !mem_done) |=> transfer_active)
    else $error("transfer flag dropped before memory completion");

  chk_xfer_end: assert property ( // see RULE10
    (transfer_active && !pipeline_active && mem_done) |=> !transfer_active)
    else $error("transfer flag did not drop after memory completion");

  chk_ro_flags: assert property ( // see RULE13
    (wr && !wr_launch && !transfer_pending) |=> !transfer_pending)
    else $error("register write raised the pending flag");

  chk_mode_hold: assert property ( // see RULE13
    (!wr_mode) |=> $stable(st_reg.mode))
    else $error("mode fields changed without a mode write");

  chk_start_once: assert property ( // see RULE4
    op_start |=> !op_start)
    else $error("issue pulse longer than one cycle");

  chk_pending_busy: assert property ( // see RULE4
    (transfer_pending && transfer_active) |=> transfer_pending)
    else $error("queued operation dropped while busy");

  chk_pending_take: assert property ( // see RULE4
    (transfer_pending && !transfer_active && !wr_launch) |=> !transfer_pending)
    else $error("pending flag stayed up after issue");

  chk_op_capture: assert property ( // see RULE6
    op_start |-> (op_param == $past(st_reg.param) && op_command == $past(st_reg.command)))
    else $error("issued values differ from loaded values");

  chk_op_hold: assert property ( // see RULE6
    !op_start |-> ($stable(op_param) && $stable(op_command)))
    else $error("issued values changed without an issue");

  chk_lost_flag: assert property ( // see RULE6
    ((wr_param || wr_launch) && transfer_pending && !start) |=> irq_status[BSC_IRQ_LOST])
    else $error("overwrite of queued operation not flagged");

  chk_pipe_hold: assert property ( // see RULE7
    (pipeline_active && !pipe_done) |=> pipeline_active)
    else $error("pipeline flag dropped without completion");

  chk_pipe_rise: assert property ( // see RULE7
    (!pipeline_active && !start) |=> !pipeline_active)
    else $error("pipeline flag rose without an issue");

  chk_xfer_quiet: assert property ( // see RULE9
    (!transfer_active && !start) |=> !transfer_active)
    else $error("transfer flag rose without an issue");

  chk_done_event: assert property ( // see RULE10
    (transfer_active && !pipeline_active && mem_done) |=> irq_status[BSC_IRQ_DONE])
    else $error("operation end not flagged");

  chk_mem_first: assert property ( // see RULE10
    (pipeline_active && mem_done && !pipe_done) ##[1:4] (pipeline_active && pipe_done)
    |=> !transfer_active)
    else $error("early memory completion not counted");

  chk_width_one_k: assert property ( // see RULE1
    (wr_mode && req.wdata[BSC_WIDTH_MSB:BSC_WIDTH_LSB] == BSC_WSEL_1K)
    |=> (fb_width_bytes == BSC_FB_1K))
    else $error("width code 00 does not give 1024 bytes");

  chk_width_two_k: assert property ( // see RULE1
    (wr_mode && req.wdata[BSC_WIDTH_MSB:BSC_WIDTH_LSB] == BSC_WSEL_2K)
    |=> (fb_width_bytes == BSC_FB_2K))
    else $error("width code 01 does not give 2048 bytes");

  chk_rsvd_zero: assert property ( // see RULE13
    (status_word[BSC_DATA_W-1:BSC_WIDTH_MSB+1] == '0)
    && (status_word[BSC_BIT_DEPTH-1:BSC_BIT_PENDING+1] == '0))
    else $error("reserved status bits not zero");

  chk_irq_level: assert property (
    irq == |(irq_status & irq_mask))
    else $error("interrupt level does not match masked status");

  chk_reset_zero: assert property (@(posedge core_clk) disable iff (1'b0) // see RULE12
    reset |-> (status_word == BSC_STATUS_MODE_RESET && !irq))
    else $error("status word not zero in reset");

  cov_issue: cover property (wr_launch ##[1:4] op_start);
  cov_drain: cover property (st_reg.eng == BSC_ENG_DRAIN ##[1:20] !transfer_active);
  cov_lost:  cover property (events[BSC_IRQ_LOST]);
  cov_irq:   cover property ($rose(irq));
  cov_mem_first: cover property ((pipeline_active && mem_done) ##[1:4] pipe_done);

endmodule
`default_nettype wire

// File: tb/test_blit_status_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_blit_status_config;
  import bsc_pkg::*;

  logic                  core_clk;
  logic                  reset;
  logic                  wb_cyc_i;
  logic                  wb_stb_i;
  logic                  wb_we_i;
  logic [BSC_ADDR_W-1:0] wb_adr_i;
  logic [BSC_DATA_W-1:0] wb_dat_i;
  logic [BSC_SEL_W-1:0]  wb_sel_i;
  logic                  wb_ack_o;
  logic [BSC_DATA_W-1:0] wb_dat_o;
  logic                  pipe_done;
  logic                  mem_done;
  logic                  op_start;
  logic [BSC_DATA_W-1:0] op_param;
  logic [BSC_DATA_W-1:0] op_command;
  logic [BSC_FB_W-1:0]   fb_width_bytes;
  logic                  pixel_16bpp;
  logic                  transfer_pending;
  logic                  pipeline_active;
  logic                  transfer_active;
  logic                  irq;
  int                    err_count;
  int                    comparisons;
  int                    cycles;

  bsc_blit_status_mode i_dut (
    .core_clk         (core_clk),
    .reset            (reset),
    .wb_cyc_i         (wb_cyc_i),
    .wb_stb_i         (wb_stb_i),
    .wb_we_i          (wb_we_i),
    .wb_adr_i         (wb_adr_i),
    .wb_dat_i         (wb_dat_i),
    .wb_sel_i         (wb_sel_i),
    .wb_ack_o         (wb_ack_o),
    .wb_dat_o         (wb_dat_o),
    .pipe_done        (pipe_done),
    .mem_done         (mem_done),
    .op_start         (op_start),
    .op_param         (op_param),
    .op_command       (op_command),
    .fb_width_bytes   (fb_width_bytes),
    .pixel_16bpp      (pixel_16bpp),
    .transfer_pending (transfer_pending),
    .pipeline_active  (pipeline_active),
    .transfer_active  (transfer_active),
    .irq              (irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles >= 5000) begin
      err_count++;
      $display("mismatch timeout expected end seen %0d cycles", cycles);
      report_and_stop();
    end
  end

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_small(input string what, input logic [12:0] exp, input logic [12:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The request is held until ack is sampled high at a rising edge.
  task automatic bus(input logic we, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    // Ack is looked at mid-cycle; the edge after that is the one that samples it high.
    do begin
      @(negedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    check_small("bus ack", 13'h0001, {12'h000, wb_ack_o});
    @(posedge core_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask

  task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, 4'hf, q);
    check_word(what, exp, q);
  endtask

  task automatic pulse(input logic p, input logic m);
    @(posedge core_clk);
    pipe_done <= p;
    mem_done  <= m;
    @(posedge core_clk);
    pipe_done <= 1'b0;
    mem_done  <= 1'b0;
    #1;
  endtask

  task automatic flags(input logic [2:0] exp);
    check_small("flags", {10'h000, exp},
                {10'h000, transfer_pending, pipeline_active, transfer_active});
  endtask

  task automatic test_reset();
    rd_chk("status after reset", BSC_OFF_STATUS_MODE, 32'h00000000);
    check_small("width after reset", 13'h0400, fb_width_bytes);
    check_small("depth after reset", 13'h0000, {12'h000, pixel_16bpp});
    flags(3'b000);
  endtask

  task automatic test_mode();
    logic [12:0] w;
    for (int i = 0; i < 4; i++) begin
      for (int d = 0; d < 2; d++) begin
        wr(BSC_OFF_STATUS_MODE, {21'h0, i[1:0], d[0], 8'h00}, 4'hf);
        w = (i == 0) ? 13'h0400 : (i == 1) ? 13'h0800 : 13'h1000;
        rd_chk("mode word", BSC_OFF_STATUS_MODE, {21'h0, i[1:0], d[0], 8'h00});
        check_small("width bytes", w, fb_width_bytes);
        check_small("depth", {12'h000, d[0]}, {12'h000, pixel_16bpp});
      end
    end
    wr(BSC_OFF_STATUS_MODE, 32'hffffffff, 4'hf);
    rd_chk("read-only bits", BSC_OFF_STATUS_MODE, 32'h00000700);
    wr(BSC_OFF_STATUS_MODE, 32'h00000000, 4'hd);
    rd_chk("mode lane off", BSC_OFF_STATUS_MODE, 32'h00000700);
    wr(16'h8210, 32'hffffffff, 4'hf);
    rd_chk("unmapped read", 16'h8210, 32'h00000000);
    wr(BSC_OFF_STATUS_MODE, 32'h00000000, 4'hf);
  endtask

  task automatic test_ops();
    flags(3'b000);
    wr(BSC_OFF_PARAM, 32'h00001111, 4'hf);
    wr(BSC_OFF_LAUNCH, 32'h000000a1, 4'hf);
    #1;
    check_small("first start", 13'h0001, {12'h000, op_start});
    flags(3'b011);
    rd_chk("status running", BSC_OFF_STATUS_MODE, 32'h00000003);
    wr(BSC_OFF_LAUNCH, 32'h000000b2, 4'hf);
    rd_chk("status queued", BSC_OFF_STATUS_MODE, 32'h00000007);
    wr(BSC_OFF_PARAM, 32'h00002222, 4'hf);
    rd_chk("overwrite event", BSC_OFF_IRQ_STATUS, 32'h00000004);
    check_word("running param", 32'h00001111, op_param);
    pulse(1'b1, 1'b0);
    flags(3'b101);
    pulse(1'b0, 1'b1);
    flags(3'b100);
    @(posedge core_clk);
    #1;
    check_small("second start", 13'h0001, {12'h000, op_start});
    check_word("queued param", 32'h00002222, op_param);
    check_word("queued command", 32'h000000b2, op_command);
    flags(3'b011);
  endtask

  task automatic test_irq();
    rd_chk("irq status", BSC_OFF_IRQ_STATUS, 32'h00000007);
    check_small("irq masked", 13'h0000, {12'h000, irq});
    wr(BSC_OFF_IRQ_MASK, 32'h00000002, 4'h1);
    @(posedge core_clk);
    #1;
    check_small("irq unmasked", 13'h0001, {12'h000, irq});
    wr(BSC_OFF_IRQ_STATUS, 32'h00000002, 4'h1);
    @(posedge core_clk);
    #1;
    check_small("irq cleared", 13'h0000, {12'h000, irq});
    rd_chk("irq after clear", BSC_OFF_IRQ_STATUS, 32'h00000005);
    pulse(1'b0, 1'b1);
    flags(3'b011);
    pulse(1'b1, 1'b0);
    flags(3'b000);
    @(posedge core_clk);
    #1;
    check_small("irq pipeline", 13'h0001, {12'h000, irq});
    wr(BSC_OFF_IRQ_STATUS, 32'h00000007, 4'h1);
    @(posedge core_clk);
    #1;
    check_small("irq all cleared", 13'h0000, {12'h000, irq});
    rd_chk("status idle", BSC_OFF_STATUS_MODE, 32'h00000000);
  endtask

  initial begin
    err_count   = 0;
    comparisons = 0;
    cycles      = 0;
    reset       = 1'b1;
    wb_cyc_i    = 1'b0;
    wb_stb_i    = 1'b0;
    wb_we_i     = 1'b0;
    wb_adr_i    = 16'h0000;
    wb_dat_i    = 32'h00000000;
    wb_sel_i    = 4'h0;
    pipe_done   = 1'b0;
    mem_done    = 1'b0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    test_reset();
    test_mode();
    test_ops();
    test_irq();
    report_and_stop();
  end
endmodule
`default_nettype wire
